// ===== hdl/sfr_map.svh
// Register indices, field positions and reset values of the register plane.
// Assumes inclusion by the package and the plane; definitions, no logic.
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH
`define ADDR_W 8
`define IDX_INDIRECT 4'h0
`define IDX_T0 4'h1
`define IDX_PC 4'h2
`define IDX_STATUS 4'h3
`define IDX_PTR 4'h4
`define IDX_PORTA 4'h5
`define IDX_PORTB 4'h6
`define IDX_SEC_PTR 4'h7
`define IDX_EN_A 4'h8
`define IDX_PEND_A 4'h9
`define IDX_T1_LOW 4'hA
`define IDX_T1_HIGH 4'hB
`define IDX_DUTY 4'hC
`define IDX_CTRL 4'hD
`define IDX_EN_B 4'hE
`define IDX_PEND_B 4'hF
`define ST_WDT 4
`define ST_SLEEP 3
`define ST_RW_MASK 8'hE7
`define CTL_T1_CLR 3
`define CTL_PWM_CLR 2
`define CTL_T1_HALT 1
`define CTL_T0_HALT 0
`define RST_CTRL 4'h4
`define RST_PA 7'h7F
`define RST_PB 8'hFF
`define PA_BIT_PWM 7
`define PA_BIT_T2 6
`define PA_BIT_T1 5
`define PA_BIT_T0 4
`define PA_BIT_WAKE 3
`define PB_BIT_SERIAL 6
`define PB_BIT_SYNC 5
`define T0_MAX 8'hFF
`define T1_MAX 16'hFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== hdl/sfr_pkg.sv
// Types of the register plane: bus carriers and the block state.
// Assumes the map header sits beside it.
package sfr_pkg;
  `include "sfr_map.svh"
  typedef enum logic {W_IDLE, W_RESP} wr_state_t;
  typedef struct packed {
    logic awvalid;
    logic [`ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;
  typedef struct packed {
    wr_state_t wr_st;
    logic aw_got;
    logic w_got;
    logic [`ADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    axi_rsp_t rsp;
    logic [7:0] t0;
    logic [7:0] pc;
    logic [7:0] status;
    logic [7:0] ptr;
    logic [6:0] pa_out;
    logic [7:0] pb_out;
    logic [7:0] sec;
    logic [7:0] en_a;
    logic [7:0] pend_a;
    logic [15:0] reload;
    logic [15:0] t1;
    logic [7:0] duty;
    logic [3:0] ctrl;
    logic [6:0] en_b;
    logic [6:0] pend_b;
    logic [6:0] pa_s1;
    logic [6:0] pa_s2;
    logic [6:0] pa_s3;
    logic [7:0] pb_s1;
    logic [7:0] pb_s2;
    logic [7:0] pb_s3;
    logic irq;
    logic irq_a;
    logic irq_b;
  } state_t;
endpackage

// ===== hdl/special_register_plane_irq.sv
// Special register plane 0x0 to 0xF with timers, ports and interrupt flags.
// Assumes an AXI4-Lite master on CLK and same-clock event pulses.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sfr_map.svh"
// Operation
// R1 - Index 0 reaches the register named by the primary pointer instead
// R2 - Writing 0 clears a pending flag, writing 1 leaves it alone
// R3 - PWM overflow sets pending bit 7 of group A
// R4 - Timer2 match sets pending bit 6 of group A
// R5 - Timer1 overflow sets pending bit 5 of group A
// R6 - T0_count overflow sets pending bit 4 of group A
// R7 - Wake timer timeout sets pending bit 3 of group A
// R8 - Falling edges on pins 1 and 2 set pending bits 1 and 2
// R9 - Either edge on pin 0 sets pending bit 0
// R10 - Pins 0 to 2 form one shared external interrupt A
// R11 - Enable group A, one bit per source, resets to zero
// R12 - Enable group B for serial, sync serial and pins 7 to 3
// R13 - Pin 6 takes both edges; pins 7, 5, 4, 3 falling only
// R14 - Timer1 bytes read live count, writes load reload bytes
// R15 - Timer1 cleared and held while its clear bit is one
// R16 - PWM held while its clear bit is one, set after reset
// R17 - Halt bits stop Timer1 and T0_count, reset to zero
// R18 - Port A reads pins, writes output register reset 7F
// R19 - Port B reads pins, writes output register reset FF
// R20 - Status fields reset zero, watchdog and sleep bits read only
// R21 - Pending group B holds serial bit 6 and sync serial bit 5
// R22 - Request raised while a pending flag and its enable are set
// R23 - A set event beats a same-cycle write-zero clear
module special_register_plane_irq
  import sfr_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire axi_req_t AXI_REQ,
  output axi_rsp_t AXI_RSP,
  input wire logic [6:0] PA_PIN,
  input wire logic [7:0] PB_PIN,
  input wire logic PWM_OVF,
  input wire logic T2_MATCH,
  input wire logic WAKE_TIMEOUT,
  input wire logic SERIAL_DONE,
  input wire logic SYNC_SERIAL_DONE,
  input wire logic WDT_TIMEOUT,
  input wire logic SLEEP,
  output logic [6:0] PA_OUT,
  output logic [7:0] PB_OUT,
  output logic [7:0] PWM_DUTY,
  output logic PWM_HOLD,
  output logic IRQ,
  output logic EXT_A_IRQ,
  output logic EXT_B_IRQ
);
  state_t st_reg;
  state_t st_next;
  logic t0_ovf;
  logic t1_ovf;
  logic [6:0] pa_fall;
  logic [6:0] pa_rise;
  logic [7:0] pb_fall;
  logic [7:0] pb_rise;
  logic [7:0] set_a;
  logic [6:0] set_b;
  logic [7:0] clr_a;
  logic [6:0] clr_b;
  logic [4:0] w_res;
  logic [4:0] r_res;
  logic wr_fire;
  logic ar_fire;

  // Resolve a bus address to a plane index; top bit marks a live target
  function automatic logic [4:0] resolve(input logic [7:0] addr,
                                         input logic [7:0] ptr);
    logic [3:0] idx;
    logic ok;
    idx = addr[5:2];
    ok = (addr[7:6] == 2'h0);
    if (idx == `IDX_INDIRECT) begin
      idx = ptr[3:0]; // R1
      ok = ok && (ptr[7:4] == 4'h0) && (ptr[3:0] != `IDX_INDIRECT);
    end
    return {ok, idx};
  endfunction

  // Read view of one index; pins read through the synchroniser
  function automatic logic [7:0] rd_byte(input logic [3:0] idx,
                                         input state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IDX_T0: v = s.t0;
      `IDX_PC: v = s.pc;
      `IDX_STATUS: v = s.status;
      `IDX_PTR: v = s.ptr;
      `IDX_PORTA: v = {1'b0, s.pa_s2}; // R18
      `IDX_PORTB: v = s.pb_s2; // R19
      `IDX_SEC_PTR: v = s.sec;
      `IDX_EN_A: v = s.en_a;
      `IDX_PEND_A: v = s.pend_a;
      `IDX_T1_LOW: v = s.t1[7:0]; // R14
      `IDX_T1_HIGH: v = s.t1[15:8]; // R14
      `IDX_DUTY: v = s.duty;
      `IDX_CTRL: v = {4'h0, s.ctrl};
      `IDX_EN_B: v = {1'b0, s.en_b};
      `IDX_PEND_B: v = {1'b0, s.pend_b};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Edges taken from the second and third stage, never the first
  assign pa_fall = st_reg.pa_s3 & ~st_reg.pa_s2;
  assign pa_rise = ~st_reg.pa_s3 & st_reg.pa_s2;
  assign pb_fall = st_reg.pb_s3 & ~st_reg.pb_s2;
  assign pb_rise = ~st_reg.pb_s3 & st_reg.pb_s2;

  // Timer wrap conditions
  assign t0_ovf = !st_reg.ctrl[`CTL_T0_HALT] && (st_reg.t0 == `T0_MAX);
  assign t1_ovf = !st_reg.ctrl[`CTL_T1_CLR] &&
                  !st_reg.ctrl[`CTL_T1_HALT] && (st_reg.t1 == `T1_MAX);

  // Hardware set events per flag group
  assign set_a = {PWM_OVF, // R3
                  T2_MATCH, // R4
                  t1_ovf, // R5
                  t0_ovf, // R6
                  WAKE_TIMEOUT, // R7
                  pb_fall[1], pb_fall[0], // R8
                  pa_fall[0] | pa_rise[0]}; // R9
  assign set_b = {SERIAL_DONE, SYNC_SERIAL_DONE, // R21
                  pa_fall[1], // R13
                  pb_fall[7] | pb_rise[7], // R13
                  pb_fall[6], pb_fall[3], pb_fall[2]}; // R13

  // Bus decode
  assign w_res = resolve(st_reg.waddr, st_reg.ptr);
  assign r_res = resolve(AXI_REQ.araddr, st_reg.ptr);
  assign wr_fire = (st_reg.wr_st == W_IDLE) && st_reg.aw_got &&
                   st_reg.w_got && st_reg.wstrb0 && w_res[4];
  assign ar_fire = AXI_REQ.arvalid && st_reg.rsp.arready;

  // All next-state logic
  always_comb begin
    st_next = st_reg;
    clr_a = 8'h00;
    clr_b = 7'h00;
    st_next.pa_s1 = PA_PIN;
    st_next.pa_s2 = st_reg.pa_s1;
    st_next.pa_s3 = st_reg.pa_s2;
    st_next.pb_s1 = PB_PIN;
    st_next.pb_s2 = st_reg.pb_s1;
    st_next.pb_s3 = st_reg.pb_s2;
    st_next.status[`ST_WDT] = WDT_TIMEOUT; // R20
    st_next.status[`ST_SLEEP] = SLEEP; // R20
    if (!st_reg.ctrl[`CTL_T0_HALT]) begin
      st_next.t0 = st_reg.t0 + 8'h01; // R17
    end
    if (st_reg.ctrl[`CTL_T1_CLR]) begin
      st_next.t1 = 16'h0000; // R15
    end else if (!st_reg.ctrl[`CTL_T1_HALT]) begin
      st_next.t1 = t1_ovf ? st_reg.reload : st_reg.t1 + 16'h0001; // R17
    end
    // Address and data may arrive in either order
    if (AXI_REQ.awvalid && st_reg.rsp.awready) begin
      st_next.aw_got = 1'b1;
      st_next.waddr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && st_reg.rsp.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = AXI_REQ.wdata[7:0];
      st_next.wstrb0 = AXI_REQ.wstrb[0];
    end
    unique case (st_reg.wr_st)
      W_IDLE: begin
        if (st_reg.aw_got && st_reg.w_got) begin
          st_next.wr_st = W_RESP;
          st_next.aw_got = 1'b0;
          st_next.w_got = 1'b0;
          st_next.rsp.bvalid = 1'b1;
          st_next.rsp.bresp = (st_reg.waddr[7:6] == 2'h0) ?
                              `RESP_OKAY : `RESP_SLVERR;
        end
      end
      W_RESP: begin
        if (AXI_REQ.bready) begin
          st_next.wr_st = W_IDLE;
          st_next.rsp.bvalid = 1'b0;
        end
      end
    endcase
    // Register write effects; T0_count load beats its own count
    if (wr_fire) begin
      case (w_res[3:0])
        `IDX_T0: st_next.t0 = st_reg.wdata;
        `IDX_PC: st_next.pc = st_reg.wdata;
        `IDX_STATUS: st_next.status = (st_reg.wdata & `ST_RW_MASK) |
          (st_next.status & ~`ST_RW_MASK); // R20
        `IDX_PTR: st_next.ptr = st_reg.wdata;
        `IDX_PORTA: st_next.pa_out = st_reg.wdata[6:0]; // R18
        `IDX_PORTB: st_next.pb_out = st_reg.wdata; // R19
        `IDX_SEC_PTR: st_next.sec = st_reg.wdata;
        `IDX_EN_A: st_next.en_a = st_reg.wdata; // R11
        `IDX_PEND_A: clr_a = ~st_reg.wdata; // R2
        `IDX_T1_LOW: st_next.reload[7:0] = st_reg.wdata; // R14
        `IDX_T1_HIGH: st_next.reload[15:8] = st_reg.wdata; // R14
        `IDX_DUTY: st_next.duty = st_reg.wdata;
        `IDX_CTRL: st_next.ctrl = st_reg.wdata[3:0];
        `IDX_EN_B: st_next.en_b = st_reg.wdata[6:0]; // R12
        `IDX_PEND_B: clr_b = ~st_reg.wdata[6:0]; // R2
        default: st_next.ptr = st_reg.ptr;
      endcase
    end
    // Set wins over a same-cycle clear so no event is dropped
    st_next.pend_a = (st_reg.pend_a & ~clr_a) | set_a; // R23
    st_next.pend_b = (st_reg.pend_b & ~clr_b) | set_b; // R23
    // Read channel; one read outstanding
    if (ar_fire) begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata = {24'h000000,
        r_res[4] ? rd_byte(r_res[3:0], st_reg) : 8'h00}; // R1
      st_next.rsp.rresp = (AXI_REQ.araddr[7:6] == 2'h0) ?
                          `RESP_OKAY : `RESP_SLVERR;
    end else if (st_reg.rsp.rvalid && AXI_REQ.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end
    st_next.rsp.arready = !st_next.rsp.rvalid;
    st_next.rsp.awready = !st_next.aw_got && (st_next.wr_st == W_IDLE);
    st_next.rsp.wready = !st_next.w_got && (st_next.wr_st == W_IDLE);
    // Requests lag the flags by one cycle to keep outputs registered
    st_next.irq_a = |(st_reg.pend_a[2:0] & st_reg.en_a[2:0]); // R10
    st_next.irq_b = |(st_reg.pend_b[4:0] & st_reg.en_b[4:0]);
    st_next.irq = |(st_reg.pend_a & st_reg.en_a) |
                  |(st_reg.pend_b & st_reg.en_b); // R22
  end

  // State register; reset takes constants only
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg <= '0;
      st_reg.wr_st <= W_IDLE;
      st_reg.ctrl <= `RST_CTRL; // R16
      st_reg.pa_out <= `RST_PA; // R18
      st_reg.pb_out <= `RST_PB; // R19
      // Synchronisers start at the idle pin level: no false edge
      st_reg.pa_s1 <= `RST_PA;
      st_reg.pa_s2 <= `RST_PA;
      st_reg.pa_s3 <= `RST_PA;
      st_reg.pb_s1 <= `RST_PB;
      st_reg.pb_s2 <= `RST_PB;
      st_reg.pb_s3 <= `RST_PB;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output straight from the state register
  assign AXI_RSP = st_reg.rsp;
  assign PA_OUT = st_reg.pa_out;
  assign PB_OUT = st_reg.pb_out;
  assign PWM_DUTY = st_reg.duty;
  assign PWM_HOLD = st_reg.ctrl[`CTL_PWM_CLR]; // R16
  assign IRQ = st_reg.irq;
  assign EXT_A_IRQ = st_reg.irq_a;
  assign EXT_B_IRQ = st_reg.irq_b;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_ptr_read;
    ar_fire && (AXI_REQ.araddr[5:2] == `IDX_INDIRECT) &&
    (AXI_REQ.araddr[7:6] == 2'h0) && (st_reg.ptr == {4'h0, `IDX_PTR});
  endsequence
  sequence s_pin1_fall;
    st_reg.pb_s2[0] ##1 !st_reg.pb_s2[0];
  endsequence
  sequence s_pin0_rise;
    !st_reg.pa_s2[0] ##1 st_reg.pa_s2[0];
  endsequence
  sequence s_pin6_rise;
    !st_reg.pb_s2[7] ##1 st_reg.pb_s2[7];
  endsequence

  chk_indirect_read: assert property ( // R1
    s_ptr_read |=> st_reg.rsp.rvalid &&
                   (st_reg.rsp.rdata[7:0] == $past(st_reg.ptr)))
    else $error("indirect read did not follow the pointer");
  chk_pend_clear: assert property ( // R2
    wr_fire && (w_res[3:0] == `IDX_PEND_A) && !st_reg.wdata[4] &&
    !set_a[4] |=> !st_reg.pend_a[4])
    else $error("write zero did not clear pending flag");
  chk_pwm_set: assert property ( // R3
    PWM_OVF |=> st_reg.pend_a[`PA_BIT_PWM])
    else $error("pwm overflow flag not set");
  chk_t2_set: assert property ( // R4
    T2_MATCH |=> st_reg.pend_a[`PA_BIT_T2])
    else $error("timer two flag not set");
  chk_t1_wrap: assert property ( // R5
    t1_ovf |=> st_reg.pend_a[`PA_BIT_T1] &&
               (st_reg.t1 == $past(st_reg.reload)))
    else $error("timer one wrap wrong");
  chk_pin1_edge: assert property ( // R8
    s_pin1_fall |=> st_reg.pend_a[1])
    else $error("pin one falling edge missed");
  chk_t1_clear: assert property ( // R15
    st_reg.ctrl[`CTL_T1_CLR] |=> (st_reg.t1 == 16'h0000))
    else $error("timer one not held clear");
  chk_t0_halt: assert property ( // R17
    st_reg.ctrl[`CTL_T0_HALT] && !(wr_fire && w_res[3:0] == `IDX_T0)
    |=> $stable(st_reg.t0))
    else $error("timer zero ran while halted");
  chk_irq_raise: assert property ( // R22
    (|(st_reg.pend_a & st_reg.en_a)) |=> IRQ)
    else $error("request missing for enabled flag");
  chk_set_wins: assert property ( // R23
    SERIAL_DONE && wr_fire && (w_res[3:0] == `IDX_PEND_B)
    |=> st_reg.pend_b[`PB_BIT_SERIAL])
    else $error("clear beat a set event");

  // Flag groups, enables, ports and status against their rules
  chk_pend_b_clear: assert property ( // R2
    wr_fire && (w_res[3:0] == `IDX_PEND_B) &&
    !st_reg.wdata[`PB_BIT_SYNC] && !set_b[`PB_BIT_SYNC]
    |=> !st_reg.pend_b[`PB_BIT_SYNC])
    else $error("write zero did not clear group b flag");
  chk_pend_keep: assert property ( // R2
    wr_fire && (w_res[3:0] == `IDX_PEND_A) &&
    st_reg.wdata[`PA_BIT_T2] && st_reg.pend_a[`PA_BIT_T2]
    |=> st_reg.pend_a[`PA_BIT_T2])
    else $error("write one disturbed a pending flag");
  chk_t0_set: assert property ( // R6
    t0_ovf |=> st_reg.pend_a[`PA_BIT_T0])
    else $error("timer zero flag not set");
  chk_wake_set: assert property ( // R7
    WAKE_TIMEOUT |=> st_reg.pend_a[`PA_BIT_WAKE])
    else $error("wake timer flag not set");
  chk_pin0_edge: assert property ( // R9
    s_pin0_rise |=> st_reg.pend_a[0])
    else $error("pin zero rising edge missed");
  chk_ext_a: assert property ( // R10
    (|(st_reg.pend_a[2:0] & st_reg.en_a[2:0])) |=> EXT_A_IRQ)
    else $error("group a external request missing");
  chk_en_a_write: assert property ( // R11
    wr_fire && (w_res[3:0] == `IDX_EN_A)
    |=> (st_reg.en_a == $past(st_reg.wdata)))
    else $error("enable group a not written");
  chk_en_b_write: assert property ( // R12
    wr_fire && (w_res[3:0] == `IDX_EN_B)
    |=> (st_reg.en_b == $past(st_reg.wdata[6:0])))
    else $error("enable group b not written");
  chk_pin6_edge: assert property ( // R13
    s_pin6_rise |=> st_reg.pend_b[3])
    else $error("pin six rising edge missed");
  chk_t1_read: assert property ( // R14
    ar_fire && (AXI_REQ.araddr == {2'h0, `IDX_T1_LOW, 2'h0})
    |=> (st_reg.rsp.rdata[7:0] == $past(st_reg.t1[7:0])))
    else $error("timer one low byte read wrong");
  chk_porta_write: assert property ( // R18
    wr_fire && (w_res[3:0] == `IDX_PORTA)
    |=> (PA_OUT == $past(st_reg.wdata[6:0])))
    else $error("port a output not written");
  chk_portb_write: assert property ( // R19
    wr_fire && (w_res[3:0] == `IDX_PORTB)
    |=> (PB_OUT == $past(st_reg.wdata)))
    else $error("port b output not written");
  chk_status_ro: assert property ( // R20
    wr_fire && (w_res[3:0] == `IDX_STATUS)
    |=> (st_reg.status[`ST_WDT] == $past(WDT_TIMEOUT)))
    else $error("watchdog flag took a write");
  chk_serial_set: assert property ( // R21
    SERIAL_DONE |=> st_reg.pend_b[`PB_BIT_SERIAL])
    else $error("serial done flag not set");
  chk_irq_drop: assert property ( // R22
    !(|(st_reg.pend_a & st_reg.en_a)) && !(|(st_reg.pend_b & st_reg.en_b))
    |=> !IRQ)
    else $error("request without an enabled flag");
endmodule // special_register_plane_irq

// ===== tb/core_bus_model.sv
// AXI4-Lite master standing in for the processor core.
// Assumes one clock; the bench calls wr and rd in turn.
`timescale 1ns/1ps
module core_bus_model
  import sfr_pkg::*;
(
  input wire logic CLK,
  input wire axi_rsp_t AXI_RSP,
  output axi_req_t AXI_REQ
);
  localparam int LIMIT = 200;
  logic hung = 1'h0;
  initial AXI_REQ = '0;
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'h1;
    w = 1'h1;
    @(posedge CLK);
    AXI_REQ.awaddr <= a;
    AXI_REQ.wdata <= {24'h0, d};
    AXI_REQ.wstrb <= 4'hF;
    AXI_REQ.awvalid <= 1'h1;
    AXI_REQ.wvalid <= 1'h1;
    AXI_REQ.bready <= 1'h1;
    while ((aw || w) && n < LIMIT) begin
      @(posedge CLK);
      n++;
      if (aw && AXI_RSP.awready === 1'h1) begin
        aw = 1'h0;
        AXI_REQ.awvalid <= 1'h0;
      end
      if (w && AXI_RSP.wready === 1'h1) begin
        w = 1'h0;
        AXI_REQ.wvalid <= 1'h0;
      end
    end
    // No response can show before the edge after the take
    while (AXI_RSP.bvalid !== 1'h1 && n < LIMIT) begin
      @(posedge CLK);
      n++;
    end
    r = AXI_RSP.bresp;
    AXI_REQ.bready <= 1'h0;
    if (n >= LIMIT) hung = 1'h1;
  endtask
  // Read: rready held from the start until rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    AXI_REQ.araddr <= a;
    AXI_REQ.arvalid <= 1'h1;
    AXI_REQ.rready <= 1'h1;
    do begin
      @(posedge CLK);
      n++;
    end while (AXI_RSP.arready !== 1'h1 && n < LIMIT);
    AXI_REQ.arvalid <= 1'h0;
    while (AXI_RSP.rvalid !== 1'h1 && n < LIMIT) begin
      @(posedge CLK);
      n++;
    end
    d = AXI_RSP.rdata;
    r = AXI_RSP.rresp;
    AXI_REQ.rready <= 1'h0;
    if (n >= LIMIT) hung = 1'h1;
  endtask
endmodule // core_bus_model

// ===== tb/special_register_plane_irq_tb.sv
// Self-checking bench of the register plane.
// Assumes the core model drives the register bus.
`timescale 1ns/1ps
module special_register_plane_irq_tb
  import sfr_pkg::*;
();
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic CLK;
  logic RESETN;
  axi_req_t req;
  axi_rsp_t rsp;
  logic [6:0] pa_pin;
  logic [7:0] pb_pin;
  logic pwm_ovf, t2_match, wake_to, ser_done, sync_done, wdt_to, sleep_in;
  logic [6:0] pa_out;
  logic [7:0] pb_out, duty;
  logic hold, irq, ext_a, ext_b;
  logic [1:0] resp;
  logic [31:0] data;
  int bad_count = 0;
  int check_count = 0;
  // Write, then read back; order matters for pointer and timer rows
  row_t rows [16] = '{
    '{1'h0, 8'h34, 8'h00, 8'h04}, '{1'h0, 8'h20, 8'h00, 8'h00},
    '{1'h0, 8'h38, 8'h00, 8'h00}, '{1'h0, 8'h0C, 8'h00, 8'h00},
    '{1'h1, 8'h20, 8'hA5, 8'hA5}, '{1'h1, 8'h38, 8'hFF, 8'h7F},
    '{1'h1, 8'h0C, 8'hFF, 8'hE7}, '{1'h1, 8'h30, 8'h3C, 8'h3C},
    '{1'h1, 8'h10, 8'h0C, 8'h0C}, '{1'h1, 8'h00, 8'h77, 8'h77},
    '{1'h0, 8'h30, 8'h00, 8'h77}, '{1'h1, 8'h34, 8'h0B, 8'h0B},
    '{1'h1, 8'h04, 8'h33, 8'h33}, '{1'h0, 8'h28, 8'h00, 8'h00},
    '{1'h1, 8'h28, 8'hF0, 8'h00}, '{1'h1, 8'h1C, 8'h99, 8'h99}};

  core_bus_model i_core (.CLK(CLK), .AXI_RSP(rsp), .AXI_REQ(req));

  special_register_plane_irq i_dut (
    .CLK(CLK), .RESETN(RESETN), .AXI_REQ(req), .AXI_RSP(rsp),
    .PA_PIN(pa_pin), .PB_PIN(pb_pin), .PWM_OVF(pwm_ovf),
    .T2_MATCH(t2_match), .WAKE_TIMEOUT(wake_to), .SERIAL_DONE(ser_done),
    .SYNC_SERIAL_DONE(sync_done), .WDT_TIMEOUT(wdt_to), .SLEEP(sleep_in),
    .PA_OUT(pa_out), .PB_OUT(pb_out), .PWM_DUTY(duty), .PWM_HOLD(hold),
    .IRQ(irq), .EXT_A_IRQ(ext_a), .EXT_B_IRQ(ext_b));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, e);
    i_core.rd(a, data, resp);
    check("read resp", resp, 2'h0);
    check(nm, data, {24'h0, e});
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Free-running 100 MHz clock
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    RESETN = 1'h0;
    pa_pin = 7'h7E;
    pb_pin = 8'hFF;
    {pwm_ovf, t2_match, wake_to, ser_done, sync_done} = 5'h0;
    {wdt_to, sleep_in} = 2'h0;
    wait_clk(6);
    check("pa out", pa_out, 7'h7F);
    check("pb out", pb_out, 8'hFF);
    check("pwm hold", hold, 1'h1);
    RESETN <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      if (rows[i].wr) begin
        i_core.wr(rows[i].a, rows[i].d, resp);
      end
      rd_chk("row read", rows[i].a, rows[i].e);
    end
    check("pwm hold", hold, 1'h0);
    check("duty", duty, 8'h77);
    // Pointer naming itself: the indirect read returns the pointer
    i_core.wr(8'h10, 8'h04, resp);
    rd_chk("indirect ptr", 8'h00, 8'h04);
    // Earlier overflows and pin syncing may have left flags behind
    i_core.wr(8'h24, 8'h00, resp);
    i_core.wr(8'h3C, 8'h00, resp);
    @(posedge CLK);
    {pwm_ovf, t2_match, wake_to, ser_done} <= 4'hF;
    @(posedge CLK);
    {pwm_ovf, t2_match, wake_to, ser_done} <= 4'h0;
    wait_clk(2);
    check("irq", irq, 1'h1);
    rd_chk("pending a", 8'h24, 8'hC8);
    rd_chk("pending b", 8'h3C, 8'h40);
    i_core.wr(8'h24, 8'h7F, resp);
    rd_chk("pending a", 8'h24, 8'h48);
    i_core.wr(8'h3C, 8'h00, resp);
    wait_clk(3);
    check("irq", irq, 1'h0);
    // Serial event lands in the cycle its flag is written to zero
    fork
      i_core.wr(8'h3C, 8'h00, resp);
      begin
        wait_clk(2);
        ser_done <= 1'h1;
        @(posedge CLK);
        ser_done <= 1'h0;
      end
    join
    rd_chk("set wins", 8'h3C, 8'h40);
    i_core.wr(8'h3C, 8'h00, resp);
    // PA0 rises, PB0 and PB7 fall
    pa_pin <= 7'h7F;
    pb_pin <= 8'h7E;
    wait_clk(8);
    rd_chk("pending a", 8'h24, 8'h4B);
    check("ext a", ext_a, 1'h1);
    rd_chk("pending b", 8'h3C, 8'h08);
    i_core.wr(8'h3C, 8'h00, resp);
    pb_pin <= 8'hFE;
    wait_clk(8);
    rd_chk("pending b", 8'h3C, 8'h08);
    check("ext b", ext_b, 1'h1);
    rd_chk("port a pins", 8'h14, 8'h7F);
    rd_chk("port b pins", 8'h18, 8'hFE);
    i_core.wr(8'h14, 8'h2A, resp);
    i_core.wr(8'h18, 8'h5A, resp);
    check("pa out", pa_out, 7'h2A);
    check("pb out", pb_out, 8'h5A);
    wdt_to <= 1'h1;
    sleep_in <= 1'h1;
    wait_clk(2);
    i_core.wr(8'h0C, 8'h00, resp);
    rd_chk("status", 8'h0C, 8'h18);
    // Release both timers; Timer1 climbs from zero to its first wrap
    i_core.wr(8'h2C, 8'hFF, resp);
    i_core.wr(8'h34, 8'h00, resp);
    wait_clk(65560);
    i_core.rd(8'h24, data, resp);
    check("t1 wrap flag", data[5], 1'h1);
    check("t0 wrap flag", data[4], 1'h1);
    rd_chk("t1 high", 8'h2C, 8'hFF);
    i_core.wr(8'h40, 8'h11, resp);
    check("unmapped wr", resp, 2'h2);
    i_core.rd(8'h40, data, resp);
    check("unmapped rd", resp, 2'h2);
    check("unmapped data", data, 32'h0);
    // Mid-run reset brings outputs and control back to reset values
    RESETN <= 1'h0;
    wait_clk(2);
    RESETN <= 1'h1;
    check("pa out", pa_out, 7'h7F);
    check("pwm hold", hold, 1'h1);
    rd_chk("ctrl", 8'h34, 8'h04);
    check("bus hang", i_core.hung, 1'h0);
    conclude();
  end
endmodule // special_register_plane_irq_tb
